/* hdl/gate_ctrl_pkg.sv */
package gate_ctrl_pkg;
    localparam int REG_W       = 11;
    localparam int ADDR_W      = 4;
    localparam int CLK_PERIOD_NS = 25;

    localparam logic [3:0] ADDR_GATE = 4'h7;
    localparam logic [3:0] ADDR_OP   = 4'h9;
    localparam logic [3:0] ADDR_AMP  = 4'ha;
    localparam logic [3:0] ADDR_VREG = 4'hb;

    localparam logic [10:0] GATE_RST = 11'h216;
    localparam logic [10:0] OP_RST   = 11'h020;
    localparam logic [10:0] AMP_RST  = 11'h000;
    localparam logic [10:0] VREG_RST = 11'h10a;

    localparam int GT_FREQ = 10;
    localparam int GT_FW   = 9;
    localparam int GT_PWM  = 7;
    localparam int GT_DT   = 4;
    localparam int GT_BLK  = 2;
    localparam int GT_DGL  = 0;

    localparam int OP_THERM = 10;
    localparam int OP_UV2M  = 9;
    localparam int OP_GDM   = 8;
    localparam int OP_CLAMP = 7;
    localparam int OP_WD    = 5;
    localparam int OP_OCM   = 4;
    localparam int OP_WDEN  = 3;
    localparam int OP_SLEEP = 2;
    localparam int OP_FCLR  = 1;
    localparam int OP_CPUV  = 0;

    localparam int AMP_CAL  = 8;
    localparam int AMP_BLK  = 6;
    localparam int AMP_GAIN = 0;

    localparam int VR_K   = 8;
    localparam int VR_DLY = 3;
    localparam int VR_UVM = 2;
    localparam int VR_UVL = 0;

    // Raw fault input bit positions
    localparam int FR_THERM = 0;
    localparam int FR_UV2   = 1;
    localparam int FR_GATE  = 2;
    localparam int FR_OC    = 3;
    localparam int FR_VUV   = 4;
    localparam int FR_N     = 5;

    localparam int DT_NS [8]       = '{35, 52, 88, 440, 880, 1760, 3520, 5280};
    localparam int SENSE_NS [4]    = '{0, 1750, 3500, 7000};
    localparam int AMP_BLK_NS [4]  = '{0, 500, 2500, 10000};
    localparam int GAIN_BASE_VV    = 10;
    localparam int PWM_INPUTS [4]  = '{6, 3, 1, 6};
    localparam int REF_K [4]       = '{0, 2, 4, 8};
    localparam int UV_PCT [4]      = '{90, 80, 70, 70};
    localparam int WD_MS [4]       = '{10, 20, 50, 100};
    localparam int OFF_US [4]      = '{0, 10, 50, 1000};
    localparam int NS_PER_MS       = 1000000;
    localparam int NS_PER_US       = 1000;
    localparam int CNT_W           = 23;
endpackage

/* hdl/gate_driver_control_regs.sv */
`timescale 1ns/1ps
module gate_driver_control_regs #(
    parameter logic [22:0] WD_T0_CYC  = 23'(gate_ctrl_pkg::WD_MS[0] * gate_ctrl_pkg::NS_PER_MS
                                           / gate_ctrl_pkg::CLK_PERIOD_NS),
    parameter logic [22:0] WD_T1_CYC  = 23'(gate_ctrl_pkg::WD_MS[1] * gate_ctrl_pkg::NS_PER_MS
                                           / gate_ctrl_pkg::CLK_PERIOD_NS),
    parameter logic [22:0] WD_T2_CYC  = 23'(gate_ctrl_pkg::WD_MS[2] * gate_ctrl_pkg::NS_PER_MS
                                           / gate_ctrl_pkg::CLK_PERIOD_NS),
    parameter logic [22:0] WD_T3_CYC  = 23'(gate_ctrl_pkg::WD_MS[3] * gate_ctrl_pkg::NS_PER_MS
                                           / gate_ctrl_pkg::CLK_PERIOD_NS),
    parameter logic [22:0] OFF_T1_CYC = 23'(gate_ctrl_pkg::OFF_US[1] * gate_ctrl_pkg::NS_PER_US
                                           / gate_ctrl_pkg::CLK_PERIOD_NS),
    parameter logic [22:0] OFF_T2_CYC = 23'(gate_ctrl_pkg::OFF_US[2] * gate_ctrl_pkg::NS_PER_US
                                           / gate_ctrl_pkg::CLK_PERIOD_NS),
    parameter logic [22:0] OFF_T3_CYC = 23'(gate_ctrl_pkg::OFF_US[3] * gate_ctrl_pkg::NS_PER_US
                                           / gate_ctrl_pkg::CLK_PERIOD_NS)
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [10:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [10:0] reg_rdata,
    input  wire logic        wdog_kick,
    input  wire logic        wake,
    input  wire logic [4:0]  fault_raw,
    output logic             pump_clock_select,
    output logic             freewheel_select,
    output logic      [2:0]  pwm_input_count,
    output logic      [12:0] dead_time_ns,
    output logic      [12:0] drain_sense_blank_time,
    output logic      [12:0] drain_sense_deglitch,
    output logic             amp_output_clamp_enable,
    output logic             pump_uv_threshold_select,
    output logic             fault_clear,
    output logic      [2:0]  amp_offset_cal,
    output logic      [13:0] amp_blank_ns,
    output logic      [20:0] amp_gain_vv,
    output logic      [3:0]  ref_scale_k,
    output logic      [6:0]  regulator_uv_setpoint,
    output logic             thermal_shutdown,
    output logic             supply_uv2_fault,
    output logic             gate_fault,
    output logic             shunt_overcurrent,
    output logic             regulator_uv_fault,
    output logic             watchdog_fault,
    output logic             sleep_mode,
    output logic             regulator_off
);
    typedef struct packed {
        logic [10:0] gate;
        logic [10:0] op;
        logic [10:0] amp;
        logic [10:0] vreg;
        logic [10:0] rdata;
        logic [4:0]  f_s1;
        logic [4:0]  f_s2;
        logic        wake_s1;
        logic        wake_s2;
        logic        asleep;
        logic        reg_off;
        logic [22:0] off_cnt;
        logic [22:0] wd_cnt;
        logic        wd_fault;
    } state_t;

    state_t q;
    state_t d;
    logic [22:0] wd_lim;
    logic [22:0] off_lim;
    logic        sleep_wr;

    always_comb begin
        case (q.op[gate_ctrl_pkg::OP_WD +: 2])
            2'h0:    wd_lim = WD_T0_CYC;
            2'h1:    wd_lim = WD_T1_CYC;
            2'h2:    wd_lim = WD_T2_CYC;
            default: wd_lim = WD_T3_CYC;
        endcase
        case (q.vreg[gate_ctrl_pkg::VR_DLY +: 2])
            2'h0:    off_lim = 23'h000000;
            2'h1:    off_lim = OFF_T1_CYC;
            2'h2:    off_lim = OFF_T2_CYC;
            default: off_lim = OFF_T3_CYC;
        endcase
    end

    assign sleep_wr = reg_wr && !q.asleep && reg_addr == gate_ctrl_pkg::ADDR_OP
                      && reg_wdata[gate_ctrl_pkg::OP_SLEEP];

    always_comb begin
        d = q;
        d.f_s1 = fault_raw;
        d.f_s2 = q.f_s1;
        d.wake_s1 = wake;
        d.wake_s2 = q.wake_s1;
        if (reg_rd) begin
            case (reg_addr)
                gate_ctrl_pkg::ADDR_GATE: d.rdata = q.gate;
                gate_ctrl_pkg::ADDR_OP:   d.rdata = q.op;
                gate_ctrl_pkg::ADDR_AMP:  d.rdata = q.amp;
                gate_ctrl_pkg::ADDR_VREG: d.rdata = q.vreg;
                default:                  d.rdata = 11'h000;
            endcase
        end
        // Full words stored, reserved bits included; ignored while asleep
        if (reg_wr && !q.asleep) begin
            case (reg_addr)
                gate_ctrl_pkg::ADDR_GATE: d.gate = reg_wdata;
                gate_ctrl_pkg::ADDR_OP:   d.op = reg_wdata;
                gate_ctrl_pkg::ADDR_AMP:  d.amp = reg_wdata;
                gate_ctrl_pkg::ADDR_VREG: d.vreg = reg_wdata;
                default: ;
            endcase
        end
        // Sleep entry: delay taken from the old setting, then all defaults
        if (sleep_wr) begin
            d.asleep = 1'b1;
            d.reg_off = 1'b0;
            d.off_cnt = off_lim;
            d.gate = gate_ctrl_pkg::GATE_RST;
            d.op = gate_ctrl_pkg::OP_RST;
            d.amp = gate_ctrl_pkg::AMP_RST;
            d.vreg = gate_ctrl_pkg::VREG_RST;
        end else if (q.asleep) begin
            if (q.wake_s2) begin
                d.asleep = 1'b0;
                d.reg_off = 1'b0;
            end else if (!q.reg_off) begin
                if (q.off_cnt == 23'h000000) begin
                    d.reg_off = 1'b1;
                end else begin
                    d.off_cnt = q.off_cnt - 23'h000001;
                end
            end
        end
        if (q.op[gate_ctrl_pkg::OP_FCLR]) begin
            d.wd_fault = 1'b0;
        end
        if (q.op[gate_ctrl_pkg::OP_WDEN] && !q.asleep) begin
            if (wdog_kick) begin
                d.wd_cnt = 23'h000000;
            end else if (q.wd_cnt >= wd_lim - 23'h000001) begin
                d.wd_cnt = 23'h000000;
                d.wd_fault = 1'b1;
            end else begin
                d.wd_cnt = q.wd_cnt + 23'h000001;
            end
        end else begin
            d.wd_cnt = 23'h000000;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q <= '0;
            q.gate <= gate_ctrl_pkg::GATE_RST;
            q.op <= gate_ctrl_pkg::OP_RST;
            q.amp <= gate_ctrl_pkg::AMP_RST;
            q.vreg <= gate_ctrl_pkg::VREG_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign pump_clock_select = q.gate[gate_ctrl_pkg::GT_FREQ];
    assign freewheel_select = q.gate[gate_ctrl_pkg::GT_FW];
    assign pwm_input_count = 3'(gate_ctrl_pkg::PWM_INPUTS[q.gate[gate_ctrl_pkg::GT_PWM +: 2]]);
    assign dead_time_ns = 13'(gate_ctrl_pkg::DT_NS[q.gate[gate_ctrl_pkg::GT_DT +: 3]]);
    assign drain_sense_blank_time = 13'(gate_ctrl_pkg::SENSE_NS[q.gate[gate_ctrl_pkg::GT_BLK +: 2]]);
    assign drain_sense_deglitch = 13'(gate_ctrl_pkg::SENSE_NS[q.gate[gate_ctrl_pkg::GT_DGL +: 2]]);
    assign amp_output_clamp_enable = q.op[gate_ctrl_pkg::OP_CLAMP];
    assign pump_uv_threshold_select = q.op[gate_ctrl_pkg::OP_CPUV];
    assign fault_clear = q.op[gate_ctrl_pkg::OP_FCLR];
    assign amp_offset_cal = q.amp[gate_ctrl_pkg::AMP_CAL +: 3];
    assign amp_blank_ns = 14'(gate_ctrl_pkg::AMP_BLK_NS[q.amp[gate_ctrl_pkg::AMP_BLK +: 2]]);
    // Code 00 is reserved and shows as zero
    assign ref_scale_k = 4'(gate_ctrl_pkg::REF_K[q.vreg[gate_ctrl_pkg::VR_K +: 2]]);
    assign regulator_uv_setpoint = 7'(gate_ctrl_pkg::UV_PCT[q.vreg[gate_ctrl_pkg::VR_UVL +: 2]]);

    for (genvar i = 0; i < 3; i++) begin : g_gain
        assign amp_gain_vv[7*i +: 7] = 7'(gate_ctrl_pkg::GAIN_BASE_VV) << q.amp[2*i +: 2];
    end

    assign thermal_shutdown = q.f_s2[gate_ctrl_pkg::FR_THERM] && q.op[gate_ctrl_pkg::OP_THERM];
    assign supply_uv2_fault = q.f_s2[gate_ctrl_pkg::FR_UV2] && !q.op[gate_ctrl_pkg::OP_UV2M];
    assign gate_fault = q.f_s2[gate_ctrl_pkg::FR_GATE] && !q.op[gate_ctrl_pkg::OP_GDM];
    assign shunt_overcurrent = q.f_s2[gate_ctrl_pkg::FR_OC] && !q.op[gate_ctrl_pkg::OP_OCM];
    assign regulator_uv_fault = q.f_s2[gate_ctrl_pkg::FR_VUV] && !q.vreg[gate_ctrl_pkg::VR_UVM];
    assign watchdog_fault = q.wd_fault;
    assign sleep_mode = q.asleep;
    assign regulator_off = q.reg_off;

    rst_defaults_a: assert property (@(posedge clock) $rose(rst_b) |-> q.gate == gate_ctrl_pkg::GATE_RST
        && q.op == gate_ctrl_pkg::OP_RST && q.vreg == gate_ctrl_pkg::VREG_RST && !sleep_mode)
        else $error("registers not at defaults after reset");
    sleep_defaults_a: assert property (@(posedge clock) disable iff (!rst_b)
        sleep_wr |=> sleep_mode && q.gate == gate_ctrl_pkg::GATE_RST && q.op == gate_ctrl_pkg::OP_RST)
        else $error("sleep entry did not restore defaults");
    off_now_a: assert property (@(posedge clock) disable iff (!rst_b)
        sleep_wr && q.vreg[gate_ctrl_pkg::VR_DLY +: 2] == 2'h0 && !$past(wake) |=> !regulator_off ##1 regulator_off)
        else $error("regulator not off right after zero delay");
    off_10us_a: assert property (@(posedge clock) disable iff (!rst_b)
        sleep_wr && q.vreg[gate_ctrl_pkg::VR_DLY +: 2] == 2'h1 |-> ##[398:404] (regulator_off || !sleep_mode))
        else $error("regulator off delay wrong");
    wd_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
        !q.op[gate_ctrl_pkg::OP_WDEN] |=> q.wd_cnt == 23'h000000 && !$rose(watchdog_fault))
        else $error("watchdog ran while off");
    set_wins_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.op[gate_ctrl_pkg::OP_WDEN] && !q.asleep && !wdog_kick && q.wd_cnt >= wd_lim - 23'h000001
        |=> watchdog_fault)
        else $error("watchdog expiry lost");
    gate_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        (fault_raw[gate_ctrl_pkg::FR_GATE] && !q.op[gate_ctrl_pkg::OP_GDM] && !reg_wr)[*3] |-> gate_fault)
        else $error("gate fault not reported");
    therm_en_a: assert property (@(posedge clock) disable iff (!rst_b)
        !q.op[gate_ctrl_pkg::OP_THERM] |-> !thermal_shutdown)
        else $error("thermal shutdown while disabled");
    read_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_rd && reg_addr == gate_ctrl_pkg::ADDR_GATE |=> reg_rdata == $past(q.gate))
        else $error("gate timing readback wrong");
    wr_keep_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_wr && !q.asleep && reg_addr == gate_ctrl_pkg::ADDR_VREG |=> q.vreg == $past(reg_wdata))
        else $error("regulator word not stored whole");
    dt_max_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.gate[gate_ctrl_pkg::GT_DT +: 3] == 3'h7 |-> dead_time_ns == 13'h14a0)
        else $error("largest gap decode wrong");

    // Mask bits act at once; only the raw fault waits for its synchroniser
    uv2_hide_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.op[gate_ctrl_pkg::OP_UV2M]
        |-> !supply_uv2_fault)
        else $error("supply uv2 fault shown while masked");

    uv2_show_a: assert property (@(posedge clock) disable iff (!rst_b)
        (fault_raw[gate_ctrl_pkg::FR_UV2] && !q.op[gate_ctrl_pkg::OP_UV2M] && !reg_wr)[*3]
        |-> supply_uv2_fault)
        else $error("supply uv2 fault not reported");

    gate_hide_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.op[gate_ctrl_pkg::OP_GDM]
        |-> !gate_fault)
        else $error("gate fault shown while masked");

    ocp_hide_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.op[gate_ctrl_pkg::OP_OCM]
        |-> !shunt_overcurrent)
        else $error("shunt overcurrent shown while masked");

    ocp_show_a: assert property (@(posedge clock) disable iff (!rst_b)
        (fault_raw[gate_ctrl_pkg::FR_OC] && !q.op[gate_ctrl_pkg::OP_OCM] && !reg_wr)[*3]
        |-> shunt_overcurrent)
        else $error("shunt overcurrent not reported");

    vreg_hide_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.vreg[gate_ctrl_pkg::VR_UVM]
        |-> !regulator_uv_fault)
        else $error("regulator uv shown while masked");

    vreg_show_a: assert property (@(posedge clock) disable iff (!rst_b)
        (fault_raw[gate_ctrl_pkg::FR_VUV] && !q.vreg[gate_ctrl_pkg::VR_UVM] && !reg_wr)[*3]
        |-> regulator_uv_fault)
        else $error("regulator uv not reported");

    therm_on_a: assert property (@(posedge clock) disable iff (!rst_b)
        (fault_raw[gate_ctrl_pkg::FR_THERM] && q.op[gate_ctrl_pkg::OP_THERM] && !reg_wr)[*3]
        |-> thermal_shutdown)
        else $error("thermal shutdown missing while enabled");

    clamp_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_wr && !sleep_mode && reg_addr == gate_ctrl_pkg::ADDR_OP && !reg_wdata[gate_ctrl_pkg::OP_SLEEP]
        |=> amp_output_clamp_enable == $past(reg_wdata[gate_ctrl_pkg::OP_CLAMP]))
        else $error("amplifier clamp not taken from write");

    pump_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_wr && !sleep_mode && reg_addr == gate_ctrl_pkg::ADDR_GATE
        |=> pump_clock_select == $past(reg_wdata[gate_ctrl_pkg::GT_FREQ]))
        else $error("pump clock select not taken from write");

    fw_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_wr && !sleep_mode && reg_addr == gate_ctrl_pkg::ADDR_GATE
        |=> freewheel_select == $past(reg_wdata[gate_ctrl_pkg::GT_FW]))
        else $error("freewheel select not taken from write");

    pwm_one_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.gate[gate_ctrl_pkg::GT_PWM +: 2] == 2'h2
        |-> pwm_input_count == 3'h1)
        else $error("single input scheme decode wrong");

    blank_max_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.gate[gate_ctrl_pkg::GT_BLK +: 2] == 2'h3
        |-> drain_sense_blank_time == 13'h1b58)
        else $error("longest drain blanking decode wrong");

    dgl_mid_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.gate[gate_ctrl_pkg::GT_DGL +: 2] == 2'h2
        |-> drain_sense_deglitch == 13'h0dac)
        else $error("drain deglitch decode wrong");

    cal_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_wr && !sleep_mode && reg_addr == gate_ctrl_pkg::ADDR_AMP
        |=> amp_offset_cal == $past(reg_wdata[gate_ctrl_pkg::AMP_CAL +: 3]))
        else $error("offset calibration bits not taken from write");

    amp_blank_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.amp[gate_ctrl_pkg::AMP_BLK +: 2] == 2'h3
        |-> amp_blank_ns == 14'h2710)
        else $error("longest amplifier blanking decode wrong");

    gain_max_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.amp[gate_ctrl_pkg::AMP_GAIN + 4 +: 2] == 2'h3
        |-> amp_gain_vv[20:14] == 7'h50)
        else $error("third amplifier top gain wrong");

    ref_max_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.vreg[gate_ctrl_pkg::VR_K +: 2] == 2'h3
        |-> ref_scale_k == 4'h8)
        else $error("largest reference scale wrong");

    uv_low_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.vreg[gate_ctrl_pkg::VR_UVL +: 2] == 2'h3
        |-> regulator_uv_setpoint == 7'h46)
        else $error("lowest regulator uv set point wrong");

    wake_exit_a: assert property (@(posedge clock) disable iff (!rst_b)
        sleep_mode && q.wake_s2
        |=> !sleep_mode && !regulator_off)
        else $error("wake did not end sleep");

    asleep_keep_a: assert property (@(posedge clock) disable iff (!rst_b)
        sleep_mode && reg_wr
        |=> q.gate == $past(q.gate) && q.amp == $past(q.amp))
        else $error("register changed by write while asleep");

    kick_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        q.op[gate_ctrl_pkg::OP_WDEN] && !sleep_mode && wdog_kick
        |=> q.wd_cnt == 23'h000000)
        else $error("watchdog kick did not restart count");

    clear_wd_a: assert property (@(posedge clock) disable iff (!rst_b)
        fault_clear && !q.op[gate_ctrl_pkg::OP_WDEN]
        |=> !watchdog_fault)
        else $error("fault clear left watchdog fault set");

    sleep_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        sleep_mode && !regulator_off && !q.wake_s2 && q.off_cnt != 23'h000000
        |=> !regulator_off)
        else $error("regulator off before delay ran out");

    sleep_c: cover property (@(posedge clock) disable iff (!rst_b) sleep_wr);
    off_c: cover property (@(posedge clock) disable iff (!rst_b) $rose(regulator_off));
    wdf_c: cover property (@(posedge clock) disable iff (!rst_b) $rose(watchdog_fault));
    wake_c: cover property (@(posedge clock) disable iff (!rst_b) $fell(sleep_mode));
    kick_c: cover property (@(posedge clock) disable iff (!rst_b) q.op[gate_ctrl_pkg::OP_WDEN] && wdog_kick);
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clock, rst_b, reg_wr, reg_rd, wdog_kick, wake, b;
    logic        pump_clock_select, freewheel_select, amp_output_clamp_enable, pump_uv_threshold_select;
    logic        fault_clear, thermal_shutdown, supply_uv2_fault, gate_fault, shunt_overcurrent;
    logic        regulator_uv_fault, watchdog_fault, sleep_mode, regulator_off;
    logic [1:0]  j, k, kc, c;
    logic [2:0]  pwm_input_count, amp_offset_cal, i;
    logic [3:0]  reg_addr, ref_scale_k;
    logic [4:0]  fault_raw;
    logic [6:0]  regulator_uv_setpoint;
    logic [10:0] reg_wdata, reg_rdata;
    logic [12:0] dead_time_ns, drain_sense_blank_time, drain_sense_deglitch;
    logic [13:0] amp_blank_ns;
    logic [20:0] amp_gain_vv;
    int          mismatches, checked, cycles, n, t;
    int          dt_tab[8] = '{35, 52, 88, 440, 880, 1760, 3520, 5280};
    int          sns_tab[4] = '{0, 1750, 3500, 7000};
    int          blk_tab[4] = '{0, 500, 2500, 10000};
    int          pwm_tab[4] = '{6, 3, 1, 6};
    int          uv_tab[4] = '{90, 80, 70, 70};
    // Off delay in cycles: 10 us and 50 us at 25 ns, then the shortened longest delay
    int          off_tab[4] = '{0, 400, 2000, 16};

    // Short watchdog counts and a short longest off delay keep the run brief
    gate_driver_control_regs #(.WD_T0_CYC(23'h14), .WD_T1_CYC(23'h28), .WD_T2_CYC(23'h3c),
        .WD_T3_CYC(23'h50), .OFF_T3_CYC(23'h10)) DUT (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdog_kick(wdog_kick), .wake(wake), .fault_raw(fault_raw),
        .pump_clock_select(pump_clock_select), .freewheel_select(freewheel_select),
        .pwm_input_count(pwm_input_count), .dead_time_ns(dead_time_ns),
        .drain_sense_blank_time(drain_sense_blank_time), .drain_sense_deglitch(drain_sense_deglitch),
        .amp_output_clamp_enable(amp_output_clamp_enable), .pump_uv_threshold_select(pump_uv_threshold_select),
        .fault_clear(fault_clear), .amp_offset_cal(amp_offset_cal), .amp_blank_ns(amp_blank_ns),
        .amp_gain_vv(amp_gain_vv), .ref_scale_k(ref_scale_k), .regulator_uv_setpoint(regulator_uv_setpoint),
        .thermal_shutdown(thermal_shutdown), .supply_uv2_fault(supply_uv2_fault), .gate_fault(gate_fault),
        .shunt_overcurrent(shunt_overcurrent), .regulator_uv_fault(regulator_uv_fault),
        .watchdog_fault(watchdog_fault), .sleep_mode(sleep_mode), .regulator_off(regulator_off));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic step(input int cnt);
        repeat (cnt) @(negedge clock);
    endtask

    // Extra cycle lets the field outputs settle
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [10:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        check(reg_rdata, exp);
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        {rst_b, reg_wr, reg_rd, wdog_kick, wake} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 11'h000;
        fault_raw = 5'h00;
        step(20);
        rst_b = 1'b1;
        rdchk(4'h7, 11'h216);
        rdchk(4'h9, 11'h020);
        rdchk(4'ha, 11'h000);
        rdchk(4'hb, 11'h10a);
        check(watchdog_fault, 1'b0);
        $display("Test reset values done");
        wr(4'ha, 11'h7ff);
        rdchk(4'ha, 11'h7ff);
        wr(4'hb, 11'h7e5);
        rdchk(4'hb, 11'h7e5);
        wr(4'h8, 11'h7ff);
        rdchk(4'h8, 11'h000);
        rdchk(4'hc, 11'h000);
        rdchk(4'h7, 11'h216);
        $display("Test readback done");
        for (n = 0; n < 8; n++) begin
            i = n[2:0];
            j = i[1:0] + 2'h1;
            k = j + 2'h1;
            kc = 2'(n % 3 + 1);
            wr(4'h7, {i[0], i[1], i[1:0], i, i[1:0], j});
            wr(4'ha, {i, j, i[1:0], j, k});
            wr(4'hb, {1'b0, kc, 3'h0, 2'h1, 1'b0, i[1:0]});
            check(pump_clock_select, i[0]);
            check(freewheel_select, i[1]);
            check(pwm_input_count, pwm_tab[i[1:0]]);
            check(dead_time_ns, dt_tab[i]);
            check(drain_sense_blank_time, sns_tab[i[1:0]]);
            check(drain_sense_deglitch, sns_tab[j]);
            check(amp_offset_cal, i);
            check(amp_blank_ns, blk_tab[j]);
            check(amp_gain_vv, {7'(10 << i[1:0]), 7'(10 << j), 7'(10 << k)});
            check(ref_scale_k, 1 << kc);
            check(regulator_uv_setpoint, uv_tab[i[1:0]]);
        end
        $display("Test field decode done");
        fault_raw = 5'h1f;
        for (n = 0; n < 2; n++) begin
            b = n[0];
            wr(4'h9, b ? 11'h7b1 : 11'h020);
            wr(4'hb, b ? 11'h10e : 11'h10a);
            step(3);
            check(thermal_shutdown, b);
            check(supply_uv2_fault, !b);
            check(gate_fault, !b);
            check(amp_output_clamp_enable, b);
            check(shunt_overcurrent, !b);
            check(pump_uv_threshold_select, b);
            check(regulator_uv_fault, !b);
        end
        fault_raw = 5'h00;
        $display("Test masks done");
        for (n = 0; n < 4; n++) begin
            wr(4'h9, 11'(n << 5) | 11'h008);
            wdog_kick = 1'b1;
            step(1);
            wdog_kick = 1'b0;
            step(20 * (n + 1) - 4);
            check(watchdog_fault, 1'b0);
            step(8);
            check(watchdog_fault, 1'b1);
            wr(4'h9, 11'h002);
            check(fault_clear, 1'b1);
            check(watchdog_fault, 1'b0);
            wr(4'h9, 11'h020);
        end
        step(90);
        check(watchdog_fault, 1'b0);
        $display("Test watchdog done");
        for (n = 0; n < 4; n++) begin
            c = n[1:0];
            wr(4'hb, {1'b0, 2'h1, 3'h0, c, 1'b0, 2'h2});
            reg_addr = 4'h9;
            reg_wdata = 11'h024;
            reg_wr = 1'b1;
            t = 0;
            do begin
                @(negedge clock);
                reg_wr = 1'b0;
                t++;
            end while (regulator_off !== 1'b1 && t < 2100);
            check(t, off_tab[c] + 2);
            check(sleep_mode, 1'b1);
            wr(4'h7, 11'h000);
            wake = 1'b1;
            step(5);
            wake = 1'b0;
            step(1);
            check(sleep_mode, 1'b0);
            check(regulator_off, 1'b0);
            rdchk(4'h7, 11'h216);
            rdchk(4'hb, 11'h10a);
        end
        $display("Test sleep done");
        close_out();
    end
endmodule
